// ### logic/pmr_cfg_reg.sv
`timescale 1ns/10ps
// one byte of host-writable storage with write mask
module pmr_cfg_reg
  import pmr_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // stored value
  output logic      [7:0] value_q
);

  logic [7:0] value_d;

  // bits outside the write mask keep their old value
  assign value_d = (wr_data & WR_MASK) | (value_q & ~WR_MASK);

  // storage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      value_q <= RESET_VAL;
    end else if (clk_en && wr_en) begin
      value_q <= value_d;
    end
  end

endmodule

// ### logic/pmr_pkg.sv
package pmr_pkg;

  // register offsets
  localparam logic [7:0] PMR_ADDR_BAT    = 8'h00;
  localparam logic [7:0] PMR_ADDR_THERM  = 8'h01;
  localparam logic [7:0] PMR_ADDR_A_CTL  = 8'h12;
  localparam logic [7:0] PMR_ADDR_B_PRI  = 8'h20;
  localparam logic [7:0] PMR_ADDR_B_SEC  = 8'h21;
  localparam logic [7:0] PMR_ADDR_B_CTL  = 8'h22;
  localparam logic [7:0] PMR_ADDR_C_PRI  = 8'h30;
  localparam logic [7:0] PMR_ADDR_PWM4   = 8'hF5;

  // field positions
  localparam int PMR_BIT_UNMASK  = 7;
  localparam int PMR_BIT_STATUS  = 6;
  localparam int PMR_BIT_LIVE    = 5;
  localparam int PMR_BIT_RSV4    = 4;
  localparam int PMR_BIT_ON      = 7;
  localparam int PMR_BIT_PHASE   = 2;
  localparam int PMR_BIT_FLT_EN  = 1;
  localparam int PMR_BIT_PGOOD   = 0;

  // reset values
  localparam logic [7:0] PMR_RST_BAT    = 8'h00;
  localparam logic [7:0] PMR_RST_THERM  = 8'h00;
  localparam logic [7:0] PMR_RST_CTL    = 8'h00;
  localparam logic [5:0] PMR_RST_VCODE  = 6'h00;
  localparam logic [7:0] PMR_RST_PWM4   = 8'h00;

  // number of regulators with a control register
  localparam int PMR_NUM_REG = 2;

endpackage

// ### logic/pmr_regs.sv
`timescale 1ns/10ps
// Summary of operation
// - 0x00 bit 7 is read/write battery interrupt unmask, 1 unmasks.
// - 0x00 bit 6 reads 1 once a battery-level interrupt was generated.
// - 0x00 bit 5 shows live battery-below-threshold comparison.
// - 0x00 bits 3:0 are read/write battery threshold code.
// - 0x01 bit 7 is read/write thermal interrupt unmask.
// - 0x01 bit 6 reads 1 once a thermal interrupt was generated.
// - control bit 7 switches each regulator on or off.
// - control bit 2 selects 180 degree phase versus in phase.
// - control bit 1 enables fault interrupts of that regulator.
// - control bit 0 reads power-good status, read only.
// - bits 5:0 at 0x20 apply while select input low; bits 5:0 at 0x30 apply at any select level.
// - bits 5:0 at 0x21 apply while select input high.
// - pwm register at 0xF5 resets to all zero.
module pmr_regs
  import pmr_pkg::*;
#(
  parameter int NREG = PMR_NUM_REG
) (
  // clock, reset, enable
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            clk_en,
  // register port from the serial interface
  input  wire logic [7:0]      reg_addr,
  input  wire logic            reg_wr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_rd,
  output logic      [7:0]      reg_rdata,
  output logic                 reg_hit,
  // analog status inputs
  input  wire logic            battery_below_threshold_live,
  input  wire logic            thermal_event,
  input  wire logic [NREG-1:0] power_good,
  input  wire logic [NREG-1:0] regulator_fault,
  input  wire logic            voltage_select_input,
  // regulator controls
  output logic      [NREG-1:0] regulator_on,
  output logic      [NREG-1:0] regulator_phase_shift,
  output logic      [5:0]      buck_b_voltage_code,
  output logic      [5:0]      buck_c_voltage_code,
  output logic      [3:0]      battery_threshold_code,
  output logic                 pin_four_pwm_enable,
  output logic      [2:0]      pin_four_pwm_frequency,
  output logic      [3:0]      pin_four_pwm_duty,
  // interrupt
  output logic                 irq
);

  // writable-bit masks; read-only bits and reserved control bits 6:3 never store
  localparam logic [7:0] BAT_WMASK   = 8'h9F;
  localparam logic [7:0] THERM_WMASK = 8'hBF;
  localparam logic [7:0] CTL_WMASK   = 8'h86;
  localparam logic [7:0] VC_WMASK    = 8'h3F;
  localparam logic [7:0] ALL_WMASK   = 8'hFF;

  // address decode
  wire logic sel_bat   = (reg_addr == PMR_ADDR_BAT);
  wire logic sel_therm = (reg_addr == PMR_ADDR_THERM);
  wire logic sel_actl  = (reg_addr == PMR_ADDR_A_CTL);
  wire logic sel_bpri  = (reg_addr == PMR_ADDR_B_PRI);
  wire logic sel_bsec  = (reg_addr == PMR_ADDR_B_SEC);
  wire logic sel_bctl  = (reg_addr == PMR_ADDR_B_CTL);
  wire logic sel_cpri  = (reg_addr == PMR_ADDR_C_PRI);
  wire logic sel_pwm4  = (reg_addr == PMR_ADDR_PWM4);
  wire logic sel_any   = sel_bat | sel_therm | sel_actl | sel_bpri
                       | sel_bsec | sel_bctl | sel_cpri | sel_pwm4;

  logic [7:0] bat_q;
  logic [7:0] therm_q;
  logic [7:0] actl_q;
  logic [7:0] bctl_q;
  logic [7:0] bpri_q;
  logic [7:0] bsec_q;
  logic [7:0] cpri_q;
  logic [7:0] pwm4_q;

  // battery and thermal control bytes
  pmr_cfg_reg #(.RESET_VAL(PMR_RST_BAT), .WR_MASK(BAT_WMASK)) u_bat (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .wr_en   (reg_wr & sel_bat),
    .wr_data (reg_wdata),
    .value_q (bat_q)
  );

  pmr_cfg_reg #(.RESET_VAL(PMR_RST_THERM), .WR_MASK(THERM_WMASK))
    u_therm (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .wr_en   (reg_wr & sel_therm),
    .wr_data (reg_wdata),
    .value_q (therm_q)
  );

  // regulator control bytes
  pmr_cfg_reg #(.RESET_VAL(PMR_RST_CTL), .WR_MASK(CTL_WMASK)) u_actl (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .wr_en   (reg_wr & sel_actl),
    .wr_data (reg_wdata),
    .value_q (actl_q)
  );

  pmr_cfg_reg #(.RESET_VAL(PMR_RST_CTL), .WR_MASK(CTL_WMASK)) u_bctl (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .wr_en   (reg_wr & sel_bctl),
    .wr_data (reg_wdata),
    .value_q (bctl_q)
  );

  // voltage code bytes
  pmr_cfg_reg #(.RESET_VAL({2'b00, PMR_RST_VCODE}), .WR_MASK(VC_WMASK))
    u_bpri (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .wr_en   (reg_wr & sel_bpri),
    .wr_data (reg_wdata),
    .value_q (bpri_q)
  );

  pmr_cfg_reg #(.RESET_VAL({2'b00, PMR_RST_VCODE}), .WR_MASK(VC_WMASK))
    u_bsec (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .wr_en   (reg_wr & sel_bsec),
    .wr_data (reg_wdata),
    .value_q (bsec_q)
  );

  pmr_cfg_reg #(.RESET_VAL({2'b00, PMR_RST_VCODE}), .WR_MASK(VC_WMASK))
    u_cpri (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .wr_en   (reg_wr & sel_cpri),
    .wr_data (reg_wdata),
    .value_q (cpri_q)
  );

  // general purpose pwm byte
  pmr_cfg_reg #(.RESET_VAL(PMR_RST_PWM4), .WR_MASK(ALL_WMASK)) u_pwm4 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .wr_en   (reg_wr & sel_pwm4),
    .wr_data (reg_wdata),
    .value_q (pwm4_q)
  );

  // sticky status flags; raw thermal event or battery rising edge sets, host read clears
  logic       bat_stat_q;
  logic       bat_stat_d;
  logic       therm_stat_q;
  logic       therm_stat_d;
  logic       live_q;
  wire  logic bat_event;

  // rising edge of the live comparator makes one battery event
  assign bat_event = battery_below_threshold_live & ~live_q;

  // set beats the read-clear so an event in the read cycle survives
  assign bat_stat_d = bat_event
                    | (bat_stat_q & ~(reg_rd & sel_bat));
  assign therm_stat_d = thermal_event
                      | (therm_stat_q & ~(reg_rd & sel_therm));

  // status flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bat_stat_q   <= 1'b0;
      therm_stat_q <= 1'b0;
      live_q       <= 1'b0;
    end else if (clk_en) begin
      bat_stat_q   <= bat_stat_d;
      therm_stat_q <= therm_stat_d;
      live_q       <= battery_below_threshold_live;
    end
  end

  // per-regulator control and status views
  wire logic [7:0] ctl_q [NREG];
  assign ctl_q[0] = actl_q;
  assign ctl_q[1] = bctl_q;

  // control byte read: live power-good in bit 0, reserved zero
  function automatic logic [7:0] ctl_view(input logic [7:0] c,
                                          input logic       pg);
    ctl_view = (c & CTL_WMASK) | {7'h00, pg};
  endfunction

  // regulator outputs
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign regulator_on[g]          = ctl_q[g][PMR_BIT_ON];
      assign regulator_phase_shift[g] = ctl_q[g][PMR_BIT_PHASE];
    end
  endgenerate

  // fault interrupt: enabled regulators that report a fault
  logic [NREG-1:0] flt_en;
  generate
    for (g = 0; g < NREG; g++) begin : g_flt
      assign flt_en[g] = ctl_q[g][PMR_BIT_FLT_EN];
    end
  endgenerate

  // voltage selection by the select pin
  assign buck_b_voltage_code = voltage_select_input ? bsec_q[5:0]
                                                    : bpri_q[5:0];
  // third buck has only a primary code in this bank
  assign buck_c_voltage_code = cpri_q[5:0];

  // configuration field outputs
  assign battery_threshold_code = bat_q[3:0];
  assign pin_four_pwm_enable    = pwm4_q[7];
  assign pin_four_pwm_frequency = pwm4_q[6:4];
  assign pin_four_pwm_duty      = pwm4_q[3:0];

  // combined interrupt line
  assign irq = (bat_stat_q & bat_q[PMR_BIT_UNMASK])
             | (therm_stat_q & therm_q[PMR_BIT_UNMASK])
             | (|(regulator_fault & flt_en));

  // read mux
  logic [7:0] rdata_d;
  assign rdata_d =
      sel_bat   ? {bat_q[7], bat_stat_q, battery_below_threshold_live,
                   bat_q[4:0]}
    : sel_therm ? {therm_q[7], therm_stat_q, therm_q[5:0]}
    : sel_actl  ? ctl_view(actl_q, power_good[0])
    : sel_bctl  ? ctl_view(bctl_q, power_good[1])
    : sel_bpri  ? bpri_q
    : sel_bsec  ? bsec_q
    : sel_cpri  ? cpri_q
    : sel_pwm4  ? pwm4_q
    : 8'h00;

  // registered read data, captured on the read strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // hit flag combinational so the serial side can nack unmapped
  assign reg_hit = sel_any;

endmodule

// ### tb/pmr_host.sv
`timescale 1ns/10ps
// host side of the register port, one strobe per access
module pmr_host (
  // clock
  input  wire logic       ref_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // released lines are scrambled so stale values cannot pass
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

// ### tb/pmr_regs_checker.sv
`timescale 1ns/10ps
// port-level checks of the register bank
module pmr_regs_checker
  import pmr_pkg::*;
#(
  parameter int NREG = PMR_NUM_REG
) (
  // clock and request
  input wire logic            ref_clk,
  input wire logic            rst,
  input wire logic            clk_en,
  input wire logic [7:0]      reg_addr,
  input wire logic            reg_wr,
  input wire logic [7:0]      reg_wdata,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_rdata,
  input wire logic            reg_hit,
  // status and controls
  input wire logic [NREG-1:0] power_good,
  input wire logic [NREG-1:0] regulator_fault,
  input wire logic            voltage_select_input,
  input wire logic [NREG-1:0] regulator_on,
  input wire logic [NREG-1:0] regulator_phase_shift,
  input wire logic [5:0]      buck_b_voltage_code,
  input wire logic [5:0]      buck_c_voltage_code,
  input wire logic [3:0]      battery_threshold_code,
  input wire logic            pin_four_pwm_enable,
  input wire logic [2:0]      pin_four_pwm_frequency,
  input wire logic [3:0]      pin_four_pwm_duty,
  input wire logic            irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // a write taken at this edge
  sequence s_wr(logic [7:0] a);
    reg_wr && clk_en && reg_addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_rd && clk_en && reg_addr == a;
  endsequence
  property p_on;
    s_wr(PMR_ADDR_A_CTL) |=> regulator_on[0] == $past(reg_wdata[7]);
  endproperty
  property p_phase;
    s_wr(PMR_ADDR_B_CTL) |=> regulator_phase_shift[1] == $past(reg_wdata[2]);
  endproperty
  property p_pri;
    s_wr(PMR_ADDR_B_PRI) ##1 !voltage_select_input
      |-> buck_b_voltage_code == $past(reg_wdata[5:0]);
  endproperty
  property p_sec;
    s_wr(PMR_ADDR_B_SEC) ##1 voltage_select_input
      |-> buck_b_voltage_code == $past(reg_wdata[5:0]);
  endproperty
  property p_cpri;
    s_wr(PMR_ADDR_C_PRI) |=> buck_c_voltage_code == $past(reg_wdata[5:0]);
  endproperty
  property p_thr;
    s_wr(PMR_ADDR_BAT) |=> battery_threshold_code == $past(reg_wdata[3:0]);
  endproperty
  property p_miss;
    reg_rd && clk_en && !reg_hit |=> reg_rdata == 8'h00;
  endproperty
  property p_pg;
    s_rd(PMR_ADDR_A_CTL) |=> reg_rdata[0] == $past(power_good[0])
      && reg_rdata[6:3] == 4'h0;
  endproperty
  // fault enabled then fault present must reach irq
  property p_flt;
    s_wr(PMR_ADDR_A_CTL) ##0 reg_wdata[1] ##1 regulator_fault[0] |-> irq;
  endproperty
  property p_pwm;
    $fell(rst) |-> {pin_four_pwm_enable, pin_four_pwm_frequency,
      pin_four_pwm_duty} == 8'h00;
  endproperty
  a_on: assert property (p_on) else $error("enable bit lost");
  a_phase: assert property (p_phase) else $error("phase bit");
  a_pri: assert property (p_pri) else $error("primary code");
  a_sec: assert property (p_sec) else $error("secondary code");
  a_cpri: assert property (p_cpri) else $error("buck c code");
  a_thr: assert property (p_thr) else $error("threshold code");
  a_miss: assert property (p_miss) else $error("unmapped read");
  a_pg: assert property (p_pg) else $error("power good read");
  a_flt: assert property (p_flt) else $error("fault irq");
  a_pwm: assert property (p_pwm) else $error("pwm reset");
endmodule
bind pmr_regs pmr_regs_checker #(.NREG(NREG)) u_chk (.ref_clk, .rst,
  .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_hit,
  .power_good, .regulator_fault, .voltage_select_input, .regulator_on,
  .regulator_phase_shift, .buck_b_voltage_code, .buck_c_voltage_code,
  .battery_threshold_code, .pin_four_pwm_enable, .pin_four_pwm_frequency,
  .pin_four_pwm_duty, .irq);

// ### tb/tb_pmr_system_regulator_regs.sv
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_pmr_system_regulator_regs;
  import pmr_pkg::*;
  logic ref_clk = 0, rst = 1, clk_en = 1, reg_wr, reg_rd, reg_hit, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, exp_v, d;
  logic battery_below_threshold_live = 0, thermal_event = 0;
  logic voltage_select_input = 0, pin_four_pwm_enable;
  logic [1:0] power_good = 0, regulator_fault = 0, regulator_on;
  logic [1:0] regulator_phase_shift;
  logic [5:0] buck_b_voltage_code, buck_c_voltage_code;
  logic [3:0] battery_threshold_code, pin_four_pwm_duty;
  logic [2:0] pin_four_pwm_frequency;
  logic [31:0] seed = 32;
  logic [7:0] exp_q[$];
  logic rd_d = 0;
  int num_errors = 0, check_count = 0;
  logic [7:0] adr[8] = '{8'h00, 8'h01, 8'h12, 8'h20, 8'h21, 8'h22, 8'h30,
                         8'hF5};
  logic [7:0] msk[8] = '{8'h9F, 8'hBF, 8'h86, 8'h3F, 8'h3F, 8'h86, 8'h3F,
                         8'hFF};
  pmr_host host (.ref_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  pmr_regs dut (.ref_clk, .rst, .clk_en, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .reg_hit, .battery_below_threshold_live,
    .thermal_event, .power_good, .regulator_fault, .voltage_select_input,
    .regulator_on, .regulator_phase_shift, .buck_b_voltage_code,
    .buck_c_voltage_code, .battery_threshold_code, .pin_four_pwm_enable,
    .pin_four_pwm_frequency, .pin_four_pwm_duty, .irq);
  initial forever #5 ref_clk = ~ref_clk;
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // the read note is queued before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask
  task automatic complete_run();
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // read data lands one cycle after the strobe
  always @(posedge ref_clk) rd_d <= reg_rd & clk_en;
  always @(negedge ref_clk) if (rd_d) begin
    exp_v = exp_q.pop_front();
    `CHK(reg_rdata, exp_v)
  end
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (adr[i]) rd(adr[i], 8'h00);
    // random fill; read-only bits and reserved control bits 6:3 must not store
    foreach (adr[i]) begin
      d = xs();
      host.acc(1'b1, adr[i], d);
      rd(adr[i], d & msk[i]);
    end
    @(negedge ref_clk);
    `CHK({pin_four_pwm_enable, pin_four_pwm_frequency, pin_four_pwm_duty}, d)
    host.acc(1'b1, 8'h55, xs());
    rd(8'h55, 8'h00);
    host.acc(1'b1, PMR_ADDR_BAT, 8'h80);
    @(posedge ref_clk) battery_below_threshold_live <= 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK(irq, 1'b1)
    rd(PMR_ADDR_BAT, 8'hE0);
    rd(PMR_ADDR_BAT, 8'hA0);
    battery_below_threshold_live <= 1'b0;
    @(negedge ref_clk);
    `CHK(irq, 1'b0)
    host.acc(1'b1, PMR_ADDR_THERM, 8'h80);
    @(posedge ref_clk) thermal_event <= 1'b1;
    @(posedge ref_clk) thermal_event <= 1'b0;
    @(negedge ref_clk);
    `CHK(irq, 1'b1)
    rd(PMR_ADDR_THERM, 8'hC0);
    host.acc(1'b1, PMR_ADDR_A_CTL, 8'h02);
    regulator_fault <= 2'b01;
    power_good <= 2'b01;
    @(negedge ref_clk);
    `CHK(irq, 1'b1)
    rd(PMR_ADDR_A_CTL, 8'h03);
    host.acc(1'b1, PMR_ADDR_A_CTL, 8'h00);
    @(negedge ref_clk);
    `CHK(irq, 1'b0)
    host.acc(1'b1, PMR_ADDR_B_PRI, 8'h15);
    host.acc(1'b1, PMR_ADDR_B_SEC, 8'h2A);
    host.acc(1'b1, PMR_ADDR_C_PRI, 8'h0F);
    @(negedge ref_clk);
    `CHK(buck_b_voltage_code, 6'h15)
    @(posedge ref_clk) voltage_select_input <= 1'b1;
    @(negedge ref_clk);
    `CHK(buck_b_voltage_code, 6'h2A)
    // secondary rewrite while selected reaches the output at once
    host.acc(1'b1, PMR_ADDR_B_SEC, 8'h07);
    @(negedge ref_clk);
    `CHK(buck_b_voltage_code, 6'h07)
    // frozen clock enable must drop the write
    @(posedge ref_clk) clk_en <= 1'b0;
    host.acc(1'b1, PMR_ADDR_C_PRI, 8'h3F);
    clk_en <= 1'b1;
    rd(PMR_ADDR_C_PRI, 8'h0F);
    repeat (3) @(posedge ref_clk);
    complete_run();
  end
endmodule
